/* File: common/fpc_pkg.sv */
// Shared constants and types for the front panel command decoder.
`default_nettype none
package fpc_pkg;
    // -----------------------------------------------------------------
    // Command groups held in the two top bits of a command byte.
    // -----------------------------------------------------------------
    localparam logic [1:0] CMD_CFG = 2'h0;
    localparam logic [1:0] CMD_DATA = 2'h1;
    localparam logic [1:0] CMD_DISP = 2'h2;
    localparam logic [1:0] CMD_ADDR = 2'h3;
    // -----------------------------------------------------------------
    // Field positions.
    // -----------------------------------------------------------------
    localparam int CFG_NORMAL_BIT = 4;
    localparam int CFG_CLOCK_BIT = 3;
    localparam int CFG_HOTKEY_BIT = 2;
    localparam int CFG_GUARD_BIT = 0;
    localparam int FMT_RAW_BIT = 7;
    localparam int DATA_CLR_BIT = 3;
    localparam int DATA_FIXED_BIT = 2;
    // -----------------------------------------------------------------
    // Data setting operation and selector codes.
    // -----------------------------------------------------------------
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_RSVD = 2'h1;
    localparam logic [1:0] OP_READ1 = 2'h2;
    localparam logic [1:0] OP_READ2 = 2'h3;
    localparam logic [1:0] WR_MEM = 2'h0;
    localparam logic [1:0] WR_TEST_ON = 2'h1;
    localparam logic [1:0] WR_TEST_OFF = 2'h2;
    localparam logic [1:0] WR_LED = 2'h3;
    localparam logic [1:0] R2_RSVD_A = 2'h0;
    localparam logic [1:0] R2_RSVD_B = 2'h2;
    // -----------------------------------------------------------------
    // Reset values.
    // -----------------------------------------------------------------
    localparam logic [3:0] RST_LAYOUT = 4'h0;
    localparam logic [2:0] RST_PROTOCOL = 3'h0;
    localparam logic RST_RAW = 1'h1;
    localparam logic [3:0] RST_GUARD_S = 4'hA;
    localparam logic [5:0] RST_MEM_ADDR = 6'h10;
    localparam logic [3:0] RST_DIGIT = 4'h0;
    localparam logic [6:0] RST_SLAVE_ADDR = 7'h3A;
    // -----------------------------------------------------------------
    // Timing: one guard tick is one second of the 10 MHz clock.
    // -----------------------------------------------------------------
    localparam longint CLK_HZ = 10000000;
    localparam longint GUARD_TICK_S = 1;
    localparam int TICK_CYCLES = int'(CLK_HZ * GUARD_TICK_S);
    // -----------------------------------------------------------------
    // Kind of the command that is in force within a frame.
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        CK_NONE = 3'b000,
        CK_CFG = 3'b001,
        CK_DATA = 3'b010,
        CK_DISP = 3'b011,
        CK_ADDR = 3'b100
    } fpc_kind_t;
endpackage : fpc_pkg
`default_nettype wire

/* File: hw/fpc_link_rx.sv */
// Two-wire serial slave receiver that delivers written bytes.
`timescale 1ns/1ps
`default_nettype none
module fpc_link_rx
    import fpc_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = RST_SLAVE_ADDR
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic first_byte,
    output logic frame_active
);
    // -----------------------------------------------------------------
    // Pin synchronisers and edge detection.
    // -----------------------------------------------------------------
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic scl_prev_ff;
    logic sda_prev_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic addr_phase_ff;
    logic ack_phase_ff;
    logic first_ff;

    // Both pins pass two flip-flops before any logic reads them.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_prev_ff <= 1'h1;
            sda_prev_ff <= 1'h1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_pin};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            scl_prev_ff <= scl_sync_ff[1];
            sda_prev_ff <= sda_sync_ff[1];
        end
    end

    assign scl_rise = scl_sync_ff[1] & ~scl_prev_ff;
    assign scl_fall = ~scl_sync_ff[1] & scl_prev_ff;
    assign start_seen = scl_sync_ff[1] & scl_prev_ff & sda_prev_ff & ~sda_sync_ff[1];
    assign stop_seen = scl_sync_ff[1] & scl_prev_ff & ~sda_prev_ff & sda_sync_ff[1];

    // Bit framing, address match and acknowledge.
    // address before command
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            addr_phase_ff <= 1'h0;
            ack_phase_ff <= 1'h0;
            frame_active <= 1'h0;
            first_ff <= 1'h0;
            sda_oe <= 1'h0;
            byte_valid <= 1'h0;
            byte_data <= 8'h00;
            first_byte <= 1'h0;
        end else begin
            byte_valid <= 1'h0;
            if (start_seen) begin
                bit_cnt_ff <= 4'h0;
                addr_phase_ff <= 1'h1;
                ack_phase_ff <= 1'h0;
                frame_active <= 1'h0;
                sda_oe <= 1'h0;
            end else if (stop_seen) begin
                addr_phase_ff <= 1'h0;
                frame_active <= 1'h0;
                sda_oe <= 1'h0;
            end else if (scl_rise && bit_cnt_ff < 4'h8) begin
                shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && ack_phase_ff) begin
                ack_phase_ff <= 1'h0;
                sda_oe <= 1'h0;
                bit_cnt_ff <= 4'h0;
            end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                ack_phase_ff <= 1'h1;
                if (addr_phase_ff) begin
                    addr_phase_ff <= 1'h0;
                    if (shift_ff == {SLAVE_ADDR, 1'h0}) begin
                        frame_active <= 1'h1;
                        first_ff <= 1'h1;
                        sda_oe <= 1'h1;
                    end
                end else if (frame_active) begin
                    sda_oe <= 1'h1;
                    byte_valid <= 1'h1;
                    byte_data <= shift_ff;
                    first_byte <= first_ff;
                    first_ff <= 1'h0;
                end
            end
        end
    end

    // The pin is open drain, so only the enable carries data.
    assign sda_out = 1'h0;
endmodule : fpc_link_rx
`default_nettype wire

/* File: hw/fpc_cmd_decoder.sv */
// Front panel command decoder: configuration, data setting and guard timer.
// Overview of operation
// - Only the first byte after a matched slave address is a command.
// - Command bytes with top bits 00 are configuration commands.
// - Config bits set normal display, clock display, all hotkeys, guard standby.
// - A new layout blanks the display until display on is requested.
// - Selecting the layout already in force leaves layout and display state as they are; the hour digit still loads.
// - Guard period is one to fifteen seconds, zero disables it.
// - Guard expiry raises the standby request when that action is chosen.
// - Clock display blanks while the host writes in normal mode.
// - Format bit seven low selects decoded remote output.
// - Format bit seven high selects raw remote output.
// - Reset gives sixteen digit twelve segment layout, display off.
// - Reset gives the default remote protocol with raw format.
// - Guard runs ten seconds at reset, stops after the first command.
// - Third byte bits seven to four pick the hour digit.
// - Command bytes with top bits 01 are data setting commands.
// - Bits five and four select write, read one or read two.
// - Bit three restarts the guard count, period unchanged.
// - Bit two fixes the address, else it increments per byte.
// - Write selector picks memory, test on, test off or indicators.
// - Read one selector picks keys, switches, remote or flags.
// - Read two selector picks configuration or clock registers.
// - Reset gives normal mode, auto increment, address 10 hex.
// - Command bytes with top bits 10 pass to the display handler.
`timescale 1ns/1ps
`default_nettype none
module fpc_cmd_decoder
    import fpc_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter logic [6:0] SLAVE_ADDR = RST_SLAVE_ADDR
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic display_on_req,
    output logic display_on,
    output logic [3:0] layout_code,
    output logic normal_display,
    output logic clock_display,
    output logic clock_blank,
    output logic all_hotkeys,
    output logic remote_control_raw,
    output logic [2:0] remote_control_protocol,
    output logic [3:0] clock_digit,
    output logic [3:0] guard_period,
    output logic guard_running,
    output logic standby_request_output,
    output logic [1:0] data_op,
    output logic [1:0] data_sel,
    output logic fixed_addr,
    output logic test_mode,
    output logic read_request,
    output logic led_write,
    output logic mem_write,
    output logic [5:0] mem_addr,
    output logic [7:0] write_data,
    output logic disp_cmd_valid,
    output logic [7:0] disp_cmd_byte
);
    // -----------------------------------------------------------------
    // Serial receiver and byte classification.
    // -----------------------------------------------------------------
    logic byte_valid;
    logic [7:0] byte_data;
    logic first_byte;
    logic frame_active;
    fpc_kind_t kind_ff;
    logic [1:0] follow_cnt_ff;
    logic first_done_ff;
    logic [31:0] tick_cnt_ff;
    logic [3:0] sec_cnt_ff;
    logic guard_act_ff;
    logic guard_expire;
    logic is_cmd;
    logic cfg_fmt;
    logic cfg_layout;
    logic data_cmd;
    logic data_rsvd;
    logic guard_restart;
    logic data_byte;

    fpc_link_rx #(
        .SLAVE_ADDR(SLAVE_ADDR)
    ) u_rx (
        .clock(clock),
        .reset(reset),
        .scl_pin(scl_pin),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .byte_valid(byte_valid),
        .byte_data(byte_data),
        .first_byte(first_byte),
        .frame_active(frame_active)
    );

    // Byte roles within the current frame.
    assign is_cmd = byte_valid & first_byte;
    assign cfg_fmt = byte_valid & ~first_byte & (kind_ff == CK_CFG) & (follow_cnt_ff == 2'h0);
    assign cfg_layout = byte_valid & ~first_byte & (kind_ff == CK_CFG) & (follow_cnt_ff == 2'h1);
    assign data_byte = byte_valid & ~first_byte & (kind_ff == CK_ADDR);
    assign data_cmd = is_cmd & (byte_data[7:6] == CMD_DATA);
    assign data_rsvd = (byte_data[5:4] == OP_RSVD) | ((byte_data[5:4] == OP_READ2)
        & ((byte_data[1:0] == R2_RSVD_A) | (byte_data[1:0] == R2_RSVD_B)));
    assign guard_restart = data_cmd & byte_data[DATA_CLR_BIT];

    // -----------------------------------------------------------------
    // Command decoding.
    // -----------------------------------------------------------------
    // Tracks which command the following bytes belong to.
    // command byte first
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            kind_ff <= CK_NONE;
            follow_cnt_ff <= 2'h0;
            first_done_ff <= 1'h0;
        end else if (!frame_active) begin
            kind_ff <= CK_NONE;
        end else if (is_cmd) begin
            first_done_ff <= 1'h1;
            follow_cnt_ff <= 2'h0;
            case (byte_data[7:6])
                CMD_CFG: kind_ff <= CK_CFG;
                CMD_DATA: kind_ff <= CK_DATA;
                CMD_DISP: kind_ff <= CK_DISP;
                CMD_ADDR: kind_ff <= CK_ADDR;
                default: kind_ff <= CK_NONE;
            endcase
        end else if (byte_valid && follow_cnt_ff != 2'h3) begin
            follow_cnt_ff <= follow_cnt_ff + 2'h1;
        end
    end

    // Configuration command flags.
    // configuration bit meanings
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            normal_display <= 1'h1;
            clock_display <= 1'h0;
            all_hotkeys <= 1'h0;
            guard_act_ff <= 1'h1;
        end else if (is_cmd && byte_data[7:6] == CMD_CFG) begin
            normal_display <= byte_data[CFG_NORMAL_BIT];
            clock_display <= byte_data[CFG_CLOCK_BIT];
            all_hotkeys <= byte_data[CFG_HOTKEY_BIT];
            guard_act_ff <= byte_data[CFG_GUARD_BIT];
        end
    end

    // Remote output format, protocol and guard period.
    // decoded or raw
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            remote_control_raw <= RST_RAW;
            remote_control_protocol <= RST_PROTOCOL;
            guard_period <= RST_GUARD_S;
        end else if (cfg_fmt) begin
            remote_control_raw <= byte_data[FMT_RAW_BIT];
            remote_control_protocol <= byte_data[6:4];
            guard_period <= byte_data[3:0];
        end
    end

    // Layout, hour digit and display blanking.
    // layout reset value
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            layout_code <= RST_LAYOUT;
            clock_digit <= RST_DIGIT;
            display_on <= 1'h0;
        end else begin
            if (cfg_layout) begin
                clock_digit <= byte_data[7:4];
                if (byte_data[3:0] != layout_code) begin
                    layout_code <= byte_data[3:0];
                    display_on <= 1'h0;
                end else if (display_on_req) begin
                    display_on <= 1'h1;
                end
            end else if (display_on_req) begin
                display_on <= 1'h1;
            end
        end
    end

    // Clock display goes dark while the host is writing in normal mode.
    // blank during writes
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            clock_blank <= 1'h0;
        end else begin
            clock_blank <= clock_display & normal_display & frame_active;
        end
    end

    // -----------------------------------------------------------------
    // Data setting command.
    // -----------------------------------------------------------------
    // Operation, selector, addressing mode and test mode.
    // operation select
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            data_op <= OP_WRITE;
            data_sel <= WR_MEM;
            fixed_addr <= 1'h0;
            test_mode <= 1'h0;
            read_request <= 1'h0;
            led_write <= 1'h0;
        end else begin
            read_request <= 1'h0;
            led_write <= byte_valid & ~first_byte & (kind_ff == CK_DATA)
                & (data_op == OP_WRITE) & (data_sel == WR_LED);
            if (data_cmd && !data_rsvd) begin
                data_op <= byte_data[5:4];
                data_sel <= byte_data[1:0];
                fixed_addr <= byte_data[DATA_FIXED_BIT];
                read_request <= byte_data[5];
                if (byte_data[5:4] == OP_WRITE && byte_data[1:0] == WR_TEST_ON) begin
                    test_mode <= 1'h1;
                end else if (byte_data[5:4] == OP_WRITE && byte_data[1:0] == WR_TEST_OFF) begin
                    test_mode <= 1'h0;
                end
            end
        end
    end

    // Display memory pointer and write strobe.
    // address reset value
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mem_addr <= RST_MEM_ADDR;
            mem_write <= 1'h0;
            write_data <= 8'h00;
        end else begin
            mem_write <= data_byte;
            if (byte_valid && !first_byte) begin
                write_data <= byte_data;
            end
            if (is_cmd && byte_data[7:6] == CMD_ADDR) begin
                mem_addr <= byte_data[5:0];
            end else if (mem_write && !fixed_addr) begin
                mem_addr <= mem_addr + 6'h01;
            end
        end
    end

    // Display control commands leave this block as a strobe.
    // display control forward
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            disp_cmd_valid <= 1'h0;
            disp_cmd_byte <= 8'h00;
        end else begin
            disp_cmd_valid <= is_cmd & (byte_data[7:6] == CMD_DISP);
            if (is_cmd && byte_data[7:6] == CMD_DISP) begin
                disp_cmd_byte <= byte_data;
            end
        end
    end

    // -----------------------------------------------------------------
    // Guard timer.
    // -----------------------------------------------------------------
    // Enable: on at reset, off after the first command, on again by a new non-zero period.
    // guard enable
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            guard_running <= 1'h1;
        end else if (cfg_fmt) begin
            guard_running <= (byte_data[3:0] != 4'h0);
        end else if (is_cmd && !first_done_ff) begin
            guard_running <= 1'h0;
        end
    end

    assign guard_expire = guard_running & (tick_cnt_ff == 32'(TICK_LEN - 1))
        & (sec_cnt_ff + 4'h1 >= guard_period);

    // Second prescaler and second counter.
    // restart guard count
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tick_cnt_ff <= 32'h0;
            sec_cnt_ff <= 4'h0;
        end else if (!guard_running || guard_restart || cfg_fmt || guard_expire) begin
            tick_cnt_ff <= 32'h0;
            sec_cnt_ff <= 4'h0;
        end else if (tick_cnt_ff == 32'(TICK_LEN - 1)) begin
            tick_cnt_ff <= 32'h0;
            sec_cnt_ff <= sec_cnt_ff + 4'h1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end

    // Standby request is held until the host restarts the guard.
    // expiry action
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            standby_request_output <= 1'h0;
        end else if (guard_expire && guard_act_ff) begin
            standby_request_output <= 1'h1;
        end else if (guard_restart) begin
            standby_request_output <= 1'h0;
        end
    end

    // -----------------------------------------------------------------
    // Assertions and covers.
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_cfg_decode: assert property (is_cmd && byte_data[7:6] == CMD_CFG |=> kind_ff == CK_CFG)
        else $error("configuration command not decoded");
    a_data_decode: assert property (is_cmd && byte_data[7:6] == CMD_DATA |=> kind_ff == CK_DATA)
        else $error("data setting command not decoded");
    a_disp_forward: assert property (is_cmd && byte_data[7:6] == CMD_DISP |=> disp_cmd_valid)
        else $error("display control command not forwarded");
    a_layout_blank: assert property (cfg_layout && byte_data[3:0] != layout_code
        |=> !display_on && layout_code == $past(byte_data[3:0]))
        else $error("new layout did not blank the display");
    a_layout_same: assert property (cfg_layout && byte_data[3:0] == layout_code && !display_on_req
        |=> $stable(display_on) && $stable(layout_code))
        else $error("same layout changed display state");
    a_guard_first: assert property (is_cmd && !first_done_ff |=> !guard_running)
        else $error("guard still running after first command");
    a_guard_restart: assert property (guard_restart && !cfg_fmt
        |=> tick_cnt_ff == 32'h0 && sec_cnt_ff == 4'h0 && $stable(guard_period))
        else $error("guard restart failed");
    a_addr_incr: assert property (mem_write && !fixed_addr && !is_cmd
        |=> mem_addr == $past(mem_addr) + 6'h01)
        else $error("address did not increment");
    a_rsvd_ignored: assert property (data_cmd && data_rsvd
        |=> $stable(data_op) && $stable(data_sel) && $stable(test_mode))
        else $error("reserved code changed state");
    a_standby_set: assert property (guard_expire && guard_act_ff |=> standby_request_output)
        else $error("standby not requested on expiry");

    c_cfg_frame: cover property (cfg_fmt ##[1:400] cfg_layout);
    c_mem_burst: cover property (mem_write ##[1:400] mem_write);
    c_standby: cover property (standby_request_output);
endmodule : fpc_cmd_decoder
`default_nettype wire

/* File: test/fpc_host_model.sv */
// Host model that masters the two-wire serial bus towards the decoder.
`timescale 1ns/1ps
`default_nettype none
module fpc_host_model (
    input wire logic clock,
    input wire logic sda_wire,
    output logic scl_pin,
    output logic sda_low
);
    // Both lines rest released and high, so the serial clock stands still between frames.
    initial begin
        scl_pin = 1'h1;
        sda_low = 1'h0;
    end
    // One quarter of the 800 ns serial bit.
    task automatic q();
        repeat (2) @(posedge clock);
    endtask : q
    // One bit: data changes only while the serial clock is low.
    task automatic put(input logic b, output logic s);
        sda_low <= !b;
        q();
        scl_pin <= 1'h1;
        q();
        s = sda_wire;
        q();
        scl_pin <= 1'h0;
        q();
    endtask : put
    // address first, then bytes back to back.
    task automatic frame(input logic [7:0] b[$], output int acks);
        logic s;
        acks = 0;
        sda_low <= 1'h1;
        q();
        scl_pin <= 1'h0;
        q();
        foreach (b[i]) begin
            for (int k = 7; k >= 0; k--) begin
                put(b[i][k], s);
            end
            put(1'h1, s);
            acks += (s === 1'h0);
        end
        sda_low <= 1'h1;
        q();
        scl_pin <= 1'h1;
        q();
        sda_low <= 1'h0;
        q();
    endtask : frame
endmodule : fpc_host_model
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the front panel command decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock, reset, scl_pin, sda_low, sda_wire, display_on_req, sda_out, sda_oe, display_on, normal_display;
    logic clock_display, clock_blank, all_hotkeys, remote_control_raw, guard_running, standby_request_output;
    logic fixed_addr, test_mode, read_request, led_write, mem_write, disp_cmd_valid;
    logic [1:0] data_op, data_sel;
    logic [2:0] remote_control_protocol;
    logic [3:0] layout_code, clock_digit, guard_period;
    logic [5:0] mem_addr;
    logic [7:0] write_data, disp_cmd_byte;
    logic [42:0] cfg_rows [2] = '{{8'h19, 8'hA0, 8'h0A, 19'h6A00A}, {8'h04, 8'h31, 8'h53, 19'h13153}};
    logic [13:0] data_rows [6] = '{{8'h66, 6'h2A}, {8'h77, 6'h3E}, {8'h71, 6'h34}, {8'h43, 6'h0C}, {8'h41, 6'h05},
        {8'h42, 6'h08}};
    int n_mismatch = 0;
    int n_compared = 0;
    int n;
    int n_read = 0, n_led = 0, n_disp = 0, n_blank = 0;
    // Counts the one-cycle strobes and the blanked clock cycles for later checks.
    always @(posedge clock) begin
        n_read <= n_read + (read_request === 1'h1);
        n_led <= n_led + (led_write === 1'h1);
        n_disp <= n_disp + (disp_cmd_valid === 1'h1);
        n_blank <= n_blank + (clock_blank === 1'h1);
    end
    // Open-drain data line with a pull-up.
    assign sda_wire = !(sda_low || (sda_oe && !sda_out));
    fpc_host_model i_host (.clock, .sda_wire, .scl_pin, .sda_low);
    fpc_cmd_decoder #(.TICK_LEN(20)) i_dut (.clock, .reset, .scl_pin, .sda_in(sda_wire), .sda_out, .sda_oe,
        .display_on_req, .display_on, .layout_code, .normal_display, .clock_display, .clock_blank, .all_hotkeys,
        .remote_control_raw, .remote_control_protocol, .clock_digit, .guard_period, .guard_running,
        .standby_request_output, .data_op, .data_sel, .fixed_addr, .test_mode, .read_request, .led_write, .mem_write,
        .mem_addr, .write_data, .disp_cmd_valid, .disp_cmd_byte);
    // Free-running 10 MHz clock.
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    // Counts one comparison and reports a mismatch.
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, e, g);
        end
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // Main sequence: reset, guard timer, table rows, then the awkward cases.
    initial begin
        reset = 1'h1;
        display_on_req = 1'h0;
        repeat (5) @(posedge clock);
        chk("reset", 22'h018AA0, {display_on, layout_code, normal_display, remote_control_raw,
            remote_control_protocol, guard_period, guard_running, mem_addr, fixed_addr});
        reset <= 1'h0;
        for (n = 0; n < 260 && standby_request_output !== 1'h1; n++) @(posedge clock);
        chk("standby delay", 1, n > 190 && n < 215);
        if (n == 260) wrap_up();
        i_host.frame('{8'h74, 8'h48}, n);
        chk("standby cleared", 0, standby_request_output);
        repeat (250) @(posedge clock);
        chk("guard stopped", 0, standby_request_output);
        $display("test guard done");
        foreach (data_rows[i]) begin
            i_host.frame('{8'h74, data_rows[i][13:6]}, n);
            chk("data setting", data_rows[i][5:0],
                {data_op, data_sel, fixed_addr, test_mode});
        end
        chk("read strobes", 3, n_read);
        chk("no blank", 0, n_blank);
        foreach (cfg_rows[i]) begin
            i_host.frame('{8'h74, cfg_rows[i][42:35], cfg_rows[i][34:27], cfg_rows[i][26:19]}, n);
            chk("config", cfg_rows[i][18:0], {normal_display, clock_display, all_hotkeys,
                remote_control_raw, remote_control_protocol, guard_period, clock_digit, layout_code});
        end
        chk("clock blank", 1, n_blank > 0);
        $display("test rows done");
        i_host.frame('{8'h74, 8'h5F}, n);
        i_host.frame('{8'h74, 8'h70}, n);
        chk("reserved codes", 5'h04, {data_op, data_sel, fixed_addr});
        chk("reserved read", 3, n_read);
        repeat (40) @(posedge clock);
        chk("no action", 0, standby_request_output);
        i_host.frame('{8'h74, 8'h8B}, n);
        chk("display strobes", 1, n_disp);
        chk("display byte", 8'h8B, disp_cmd_byte);
        i_host.frame('{8'h74, 8'h43, 8'h5A}, n);
        chk("led strobes", 1, n_led);
        chk("led data", 8'h5A, write_data);
        i_host.frame('{8'h74, 8'hC5, 8'h11, 8'h22}, n);
        chk("acks", 4, n);
        chk("address", 6'h07, mem_addr);
        chk("data", 8'h22, write_data);
        display_on_req <= 1'h1;
        @(posedge clock);
        display_on_req <= 1'h0;
        i_host.frame('{8'h74, 8'h04, 8'h31, 8'h53}, n);
        chk("same layout", 1, display_on);
        i_host.frame('{8'h74, 8'h04, 8'h31, 8'h54}, n);
        chk("new layout", 0, display_on);
        i_host.frame('{8'h76, 8'h04, 8'h31, 8'h53}, n);
        chk("foreign acks", 0, n);
        chk("layout kept", 4'h4, layout_code);
        $display("test awkward cases done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
